/* src/ctni_cfg.svh */
`ifndef CTNI_CFG_SVH
`define CTNI_CFG_SVH
`define CTNI_OP_TEXT 32'h0fffff0c
`define CTNI_OP_SETBASE 32'h0fffff38
`define CTNI_OP_NUMBER 32'h0fffff2e
`define CTNI_OP_LOADID 32'h0fffff26
`define CTNI_OP_SETMX 32'h0fffff2a
`define CTNI_OP_GETMX 32'h0fffff33
`define CTNI_OP_GETPTR 32'h0fffff23
`define CTNI_OP_GETPROPS 32'h0fffff25
`define CTNI_OP_FILLW 32'h0fffff58
`define CTNI_OPT_HCENTRE 16'h0200
`define CTNI_OPT_VCENTRE 16'h0400
`define CTNI_OPT_RIGHT 16'h0800
`define CTNI_STRING_A 16'h1000
`define CTNI_OPT_WRAP 16'h2000
`define CTNI_OPT_TWOS_COMPLEMENT 16'h0100
`define CTNI_TAG_HDR 8'h01
`define CTNI_TAG_POSX 8'h02
`define CTNI_TAG_POSY 8'h03
`define CTNI_TAG_FILLW 8'h04
`define CTNI_TAG_GLYPH 8'h05
`define CTNI_TAG_NEWLINE 8'h06
`define CTNI_TAG_SOFTBRK 8'h07
`define CTNI_TAG_FMT 8'h08
`define CTNI_TAG_XFORM 8'h15
`define CTNI_BASE_RST 6'h0a
`define CTNI_BASE_MIN 6'h02
`define CTNI_BASE_MAX 6'h24
`define CTNI_ONE 32'h00010000
`define CTNI_ADR_WPTR 12'h400
`define CTNI_ADR_RPTR 12'h404
`define CTNI_ADR_BASE 12'h408
`define CTNI_ADR_FILLW 12'h40c
`define CTNI_CH_NUL 8'h00
`define CTNI_CH_NL 8'h0a
`define CTNI_CH_SP 8'h20
`define CTNI_CH_PCT 8'h25
`define CTNI_CH_MINUS 8'h2d
`define CTNI_CH_ZERO 8'h30
`define CTNI_CH_ALPHA 8'h37
`define CTNI_PAD_MAX 4'h9
`endif

/* src/ctni_pkg.sv */
package ctni_pkg;
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_PARAM = 9'h002,
      ST_HDR = 9'h004,
      ST_TEXT = 9'h008,
      ST_NDIV = 9'h010,
      ST_NEMIT = 9'h020,
      ST_MXOUT = 9'h040,
      ST_RESULT = 9'h080,
      ST_DONE = 9'h100
   } ctni_state_t;
   typedef enum logic [3:0] {
      K_SKIP, K_TEXT, K_NUM, K_BASE, K_FILLW, K_LOADID, K_SETMX,
      K_GETMX, K_GETPTR, K_GETPROPS
   } ctni_kind_t;
   typedef struct packed {
      logic [7:0] tag;
      logic [23:0] body;
   } ctni_dl_word_t;
endpackage

/* src/ctni_cmd_interp.sv */
`include "ctni_cfg.svh"
module ctni_cmd_interp (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [11:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [31:0] INFLATE_END,
   input wire logic [31:0] IMG_ADDR,
   input wire logic [31:0] IMG_W,
   input wire logic [31:0] IMG_H,
   output logic DL_VALID,
   output ctni_pkg::ctni_dl_word_t DL_WORD,
   output logic BUSY
);
   logic [31:0] mem [0:255];
   logic [31:0] mx_reg [0:5];
   logic [31:0] p_reg [0:2];
   logic [5:0] dig_reg [0:31];
   ctni_pkg::ctni_state_t state_reg;
   ctni_pkg::ctni_kind_t kind_reg;
   logic [9:0] wptr_reg, rptr_reg, cur_reg;
   logic [1:0] pcnt_reg, npar_reg, byte_reg;
   logic [5:0] base_reg, dcnt_reg, ecnt_reg;
   logic [23:0] fillw_reg;
   logic [31:0] mag_reg;
   logic neg_reg;
   logic [3:0] pad_reg;
   logic [2:0] k_reg;
   logic ack_reg;
   logic [31:0] rdat_reg;

   // Command decode and parameter fields.
   wire [31:0] op_word = mem[rptr_reg[9:2]];
   wire [31:0] cur_word = mem[cur_reg[9:2]];
   wire avail = cur_reg != wptr_reg;
   wire ctni_pkg::ctni_kind_t kind_w =
      (op_word == `CTNI_OP_TEXT) ? ctni_pkg::K_TEXT :
      (op_word == `CTNI_OP_NUMBER) ? ctni_pkg::K_NUM :
      (op_word == `CTNI_OP_SETBASE) ? ctni_pkg::K_BASE :
      (op_word == `CTNI_OP_FILLW) ? ctni_pkg::K_FILLW :
      (op_word == `CTNI_OP_LOADID) ? ctni_pkg::K_LOADID :
      (op_word == `CTNI_OP_SETMX) ? ctni_pkg::K_SETMX :
      (op_word == `CTNI_OP_GETMX) ? ctni_pkg::K_GETMX :
      (op_word == `CTNI_OP_GETPTR) ? ctni_pkg::K_GETPTR :
      (op_word == `CTNI_OP_GETPROPS) ? ctni_pkg::K_GETPROPS :
      ctni_pkg::K_SKIP;
   wire [1:0] npar_w = (kind_w == ctni_pkg::K_NUM) ? 2'h3 :
      (kind_w == ctni_pkg::K_TEXT) ? 2'h2 :
      (kind_w == ctni_pkg::K_BASE || kind_w == ctni_pkg::K_FILLW) ?
      2'h1 : 2'h0;
   wire [15:0] opt = p_reg[1][31:16];
   wire [4:0] font = p_reg[1][4:0];
   wire is_text = kind_reg == ctni_pkg::K_TEXT;
   wire wrap = is_text && (opt & `CTNI_OPT_WRAP) != 16'h0;
   wire fmt = is_text && (opt & `CTNI_STRING_A) != 16'h0;
   wire sgn = !is_text && (opt & `CTNI_OPT_TWOS_COMPLEMENT) != 16'h0;
   wire hc = (opt & `CTNI_OPT_HCENTRE) != 16'h0;
   wire vc = (opt & `CTNI_OPT_VCENTRE) != 16'h0;
   wire rj = (opt & `CTNI_OPT_RIGHT) != 16'h0;
   wire [3:0] width = (opt[3:0] != 4'h0 && opt[3:0] <= `CTNI_PAD_MAX) ?
      opt[3:0] : 4'h0;
   wire [2:0] hdr_last = wrap ? 3'h3 : 3'h2;
   wire [7:0] txt_byte = cur_word[{byte_reg, 3'b000} +: 8];
   wire [31:0] quot = mag_reg / {26'h0, base_reg};
   wire [31:0] rem = mag_reg % {26'h0, base_reg};
   wire [5:0] dig_out = dig_reg[5'(ecnt_reg - 6'h1)];
   wire [7:0] dig_ch = (dig_out < 6'h0a) ? `CTNI_CH_ZERO + {2'h0, dig_out} :
      `CTNI_CH_ALPHA + {2'h0, dig_out};
   wire [2:0] res_last = (kind_reg == ctni_pkg::K_GETMX) ? 3'h5 :
      (kind_reg == ctni_pkg::K_GETPROPS) ? 3'h2 : 3'h0;
   wire [31:0] res_w = (kind_reg == ctni_pkg::K_GETMX) ? mx_reg[k_reg] :
      (kind_reg == ctni_pkg::K_GETPTR) ? INFLATE_END :
      (k_reg == 3'h0) ? IMG_ADDR : (k_reg == 3'h1) ? IMG_W : IMG_H;
   wire eng_we = state_reg == ctni_pkg::ST_RESULT && avail;
   wire [31:0] num_in = p_reg[2];
   wire [4:0] nxt_dig = 5'(dcnt_reg);

   // Wishbone slave: one wait state except host writes held off by a result store; unmapped reads return zero.
   wire wb_req = WB_CYC_I && WB_STB_I && !ack_reg;
   wire wb_take = wb_req && !(WB_WE_I && eng_we);
   wire wb_mem = WB_ADR_I[11:10] == 2'b00;
   wire [31:0] wb_old = mem[WB_ADR_I[9:2]];
   wire [31:0] wb_merge;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
         assign wb_merge[8*gi +: 8] = WB_SEL_I[gi] ?
            WB_DAT_I[8*gi +: 8] : wb_old[8*gi +: 8];
      end
   endgenerate
   wire [9:0] wptr_in = {WB_SEL_I[1] ? WB_DAT_I[9:8] : wptr_reg[9:8],
      WB_SEL_I[0] ? WB_DAT_I[7:2] : wptr_reg[7:2], 2'b00};
   wire [31:0] rd_w = wb_mem ? wb_old :
      (WB_ADR_I == `CTNI_ADR_WPTR) ? {22'h0, wptr_reg} :
      (WB_ADR_I == `CTNI_ADR_RPTR) ? {22'h0, rptr_reg} :
      (WB_ADR_I == `CTNI_ADR_BASE) ? {26'h0, base_reg} :
      (WB_ADR_I == `CTNI_ADR_FILLW) ? {8'h0, fillw_reg} : 32'h0;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h0;
         wptr_reg <= 10'h0;
      end else begin
         ack_reg <= wb_take;
         rdat_reg <= wb_take ? rd_w : 32'h0;
         if (wb_take && WB_WE_I && WB_ADR_I == `CTNI_ADR_WPTR) begin
            wptr_reg <= wptr_in;
         end
      end
   end

   // Result words take the write port ahead of the host.
   always_ff @(posedge REF_CLK) begin
      if (eng_we) begin
         mem[cur_reg[9:2]] <= res_w;
      end else if (wb_take && WB_WE_I && wb_mem) begin
         mem[WB_ADR_I[9:2]] <= wb_merge;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (state_reg == ctni_pkg::ST_NDIV) begin
         dig_reg[nxt_dig] <= rem[5:0];
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= ctni_pkg::ST_IDLE;
         kind_reg <= ctni_pkg::K_SKIP;
         rptr_reg <= 10'h0;
         cur_reg <= 10'h0;
         pcnt_reg <= 2'h0;
         npar_reg <= 2'h0;
         byte_reg <= 2'h0;
         base_reg <= `CTNI_BASE_RST;
         fillw_reg <= 24'h0;
         mag_reg <= 32'h0;
         neg_reg <= 1'b0;
         pad_reg <= 4'h0;
         dcnt_reg <= 6'h0;
         ecnt_reg <= 6'h0;
         k_reg <= 3'h0;
         for (int i = 0; i < 3; i++) p_reg[i] <= 32'h0;
         for (int i = 0; i < 6; i++) mx_reg[i] <= 32'h0;
         DL_VALID <= 1'b0;
         DL_WORD <= '0;
      end else begin
         DL_VALID <= 1'b0;
         unique case (state_reg)
            ctni_pkg::ST_IDLE: begin
               if (rptr_reg != wptr_reg) begin
                  kind_reg <= kind_w;
                  npar_reg <= npar_w;
                  cur_reg <= rptr_reg + 10'h4;
                  pcnt_reg <= 2'h0;
                  k_reg <= 3'h0;
                  byte_reg <= 2'h0;
                  dcnt_reg <= 6'h0;
                  if (npar_w != 2'h0) begin
                     state_reg <= ctni_pkg::ST_PARAM;
                  end else if (kind_w == ctni_pkg::K_SETMX) begin
                     state_reg <= ctni_pkg::ST_MXOUT;
                  end else if (kind_w == ctni_pkg::K_GETMX ||
                     kind_w == ctni_pkg::K_GETPTR ||
                     kind_w == ctni_pkg::K_GETPROPS) begin
                     state_reg <= ctni_pkg::ST_RESULT;
                  end else begin
                     state_reg <= ctni_pkg::ST_DONE;
                  end
                  if (kind_w == ctni_pkg::K_LOADID) begin
                     for (int i = 0; i < 6; i++) begin
                        mx_reg[i] <= (i == 0 || i == 4) ? `CTNI_ONE :
                           32'h0;
                     end
                  end
               end
            end
            ctni_pkg::ST_PARAM: begin
               if (avail) begin
                  p_reg[pcnt_reg] <= cur_word;
                  cur_reg <= cur_reg + 10'h4;
                  pcnt_reg <= pcnt_reg + 2'h1;
                  if (pcnt_reg == npar_reg - 2'h1) begin
                     unique case (kind_reg)
                        ctni_pkg::K_TEXT: state_reg <= ctni_pkg::ST_HDR;
                        ctni_pkg::K_NUM: state_reg <= ctni_pkg::ST_NDIV;
                        default: state_reg <= ctni_pkg::ST_DONE;
                     endcase
                     if (kind_reg == ctni_pkg::K_BASE &&
                        cur_word >= {26'h0, `CTNI_BASE_MIN} &&
                        cur_word <= {26'h0, `CTNI_BASE_MAX}) begin
                        base_reg <= cur_word[5:0];
                     end
                     if (kind_reg == ctni_pkg::K_FILLW) begin
                        fillw_reg <= cur_word[23:0];
                     end
                     if (kind_reg == ctni_pkg::K_NUM) begin
                        neg_reg <= sgn && cur_word[31];
                        mag_reg <= (sgn && cur_word[31]) ? -cur_word :
                           cur_word;
                     end
                  end
               end
            end
            ctni_pkg::ST_NDIV: begin
               mag_reg <= quot;
               dcnt_reg <= dcnt_reg + 6'h1;
               if (quot == 32'h0) begin
                  state_reg <= ctni_pkg::ST_HDR;
               end
            end
            ctni_pkg::ST_HDR: begin
               DL_VALID <= 1'b1;
               unique case (k_reg)
                  3'h0: DL_WORD <= {`CTNI_TAG_HDR, 14'h0, wrap, fmt,
                     rj, vc, hc, font};
                  3'h1: DL_WORD <= {`CTNI_TAG_POSX, 8'h0, p_reg[0][15:0]};
                  3'h2: DL_WORD <= {`CTNI_TAG_POSY, 8'h0,
                     p_reg[0][31:16]};
                  default: DL_WORD <= {`CTNI_TAG_FILLW, fillw_reg};
               endcase
               k_reg <= k_reg + 3'h1;
               if (k_reg == (is_text ? hdr_last : 3'h2)) begin
                  k_reg <= 3'h0;
                  state_reg <= is_text ? ctni_pkg::ST_TEXT :
                     ctni_pkg::ST_NEMIT;
                  ecnt_reg <= dcnt_reg;
                  pad_reg <= (width > dcnt_reg[3:0] && dcnt_reg < 6'h0a) ?
                     width - dcnt_reg[3:0] : 4'h0;
               end
            end
            ctni_pkg::ST_TEXT: begin
               if (avail) begin
                  byte_reg <= byte_reg + 2'h1;
                  if (byte_reg == 2'h3 || txt_byte == `CTNI_CH_NUL) begin
                     cur_reg <= cur_reg + 10'h4;
                     byte_reg <= 2'h0;
                  end
                  if (txt_byte == `CTNI_CH_NUL) begin
                     state_reg <= ctni_pkg::ST_DONE;
                  end else begin
                     DL_VALID <= 1'b1;
                     if (!wrap && txt_byte == `CTNI_CH_NL) begin
                        DL_WORD <= {`CTNI_TAG_NEWLINE, 24'h0};
                     end else if (wrap && txt_byte == `CTNI_CH_SP) begin
                        DL_WORD <= {`CTNI_TAG_SOFTBRK, fillw_reg};
                     end else if (fmt && txt_byte == `CTNI_CH_PCT) begin
                        DL_WORD <= {`CTNI_TAG_FMT, 24'h0};
                     end else begin
                        DL_WORD <= {`CTNI_TAG_GLYPH, 16'h0, txt_byte};
                     end
                  end
               end
            end
            ctni_pkg::ST_NEMIT: begin
               DL_VALID <= 1'b1;
               if (neg_reg) begin
                  neg_reg <= 1'b0;
                  DL_WORD <= {`CTNI_TAG_GLYPH, 16'h0, `CTNI_CH_MINUS};
               end else if (pad_reg != 4'h0) begin
                  pad_reg <= pad_reg - 4'h1;
                  DL_WORD <= {`CTNI_TAG_GLYPH, 16'h0, `CTNI_CH_ZERO};
               end else begin
                  ecnt_reg <= ecnt_reg - 6'h1;
                  DL_WORD <= {`CTNI_TAG_GLYPH, 16'h0, dig_ch};
                  if (ecnt_reg == 6'h1) begin
                     state_reg <= ctni_pkg::ST_DONE;
                  end
               end
            end
            ctni_pkg::ST_MXOUT: begin
               DL_VALID <= 1'b1;
               DL_WORD <= {`CTNI_TAG_XFORM + {5'h0, k_reg},
                  mx_reg[k_reg][23:0]};
               k_reg <= k_reg + 3'h1;
               if (k_reg == 3'h5) begin
                  state_reg <= ctni_pkg::ST_DONE;
               end
            end
            ctni_pkg::ST_RESULT: begin
               if (avail) begin
                  cur_reg <= cur_reg + 10'h4;
                  k_reg <= k_reg + 3'h1;
                  if (k_reg == res_last) begin
                     state_reg <= ctni_pkg::ST_DONE;
                  end
               end
            end
            ctni_pkg::ST_DONE: begin
               rptr_reg <= cur_reg;
               state_reg <= ctni_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         BUSY <= 1'b0;
      end else begin
         BUSY <= rptr_reg != wptr_reg;
      end
   end
   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = rdat_reg;

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   wire go_setmx = state_reg == ctni_pkg::ST_IDLE &&
      rptr_reg != wptr_reg && kind_w == ctni_pkg::K_SETMX;
   sequence s_six_words;
      DL_VALID [*6];
   endsequence
   sequence s_back_idle;
      state_reg == ctni_pkg::ST_DONE ##1 state_reg == ctni_pkg::ST_IDLE;
   endsequence
   chk_base_range: assert property (
      base_reg >= `CTNI_BASE_MIN && base_reg <= `CTNI_BASE_MAX)
      else $error("radix out of range");
   chk_identity_load: assert property (
      state_reg == ctni_pkg::ST_IDLE && rptr_reg != wptr_reg &&
      kind_w == ctni_pkg::K_LOADID |-> ##1 mx_reg[0] == `CTNI_ONE &&
      mx_reg[4] == `CTNI_ONE && mx_reg[1] == 32'h0)
      else $error("identity not loaded");
   chk_setmx_burst: assert property (
      go_setmx |-> ##2 s_six_words ##0 DL_WORD.tag ==
      `CTNI_TAG_XFORM + 8'h5 ##0 s_back_idle)
      else $error("set-matrix burst wrong");
   chk_rptr_done: assert property (
      rptr_reg != $past(rptr_reg) |-> $past(state_reg) ==
      ctni_pkg::ST_DONE)
      else $error("read pointer moved early");
   chk_result_store: assert property (
      eng_we |=> mem[$past(cur_reg[9:2])] == $past(res_w) &&
      !(WB_ACK_O && $past(WB_WE_I)))
      else $error("result word not stored");
   chk_newline_tag: assert property (
      state_reg == ctni_pkg::ST_TEXT && avail && !wrap &&
      txt_byte == `CTNI_CH_NL |=> DL_VALID &&
      DL_WORD.tag == `CTNI_TAG_NEWLINE)
      else $error("newline not a break");
   chk_space_wrap: assert property (
      state_reg == ctni_pkg::ST_TEXT && avail && wrap &&
      txt_byte == `CTNI_CH_SP |=> DL_WORD.tag == `CTNI_TAG_SOFTBRK)
      else $error("space not a soft break");
   chk_string_end: assert property (
      state_reg == ctni_pkg::ST_TEXT && avail && txt_byte == `CTNI_CH_NUL
      |=> !DL_VALID ##0 s_back_idle)
      else $error("string end not honoured");
   chk_minus_first: assert property (
      state_reg == ctni_pkg::ST_NEMIT && neg_reg |=>
      DL_WORD.body[7:0] == `CTNI_CH_MINUS)
      else $error("minus sign missing");
endmodule

/* test/ctni_host_model.sv */
`include "ctni_cfg.svh"
module ctni_host_model (
   input wire logic clk,
   input wire logic [31:0] dat_i,
   input wire logic ack,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [3:0] sel,
   output logic [11:0] adr,
   output logic [31:0] dat
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] wp;
   initial begin
      wp = 10'h000;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'h0;
      adr = 12'h000;
      dat = 32'h0;
   end
   // Released address and data lines show the inverse, so stale values never look valid.
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      dat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_i;
      cyc <= 1'b0;
      stb <= 1'b0;
      adr <= ~a;
      dat <= ~d;
   endtask
   task automatic put(input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, {2'b00, wp}, d, q);
      wp = wp + 10'h004;
   endtask
   task automatic put_str(input string s);
      logic [31:0] w;
      w = 32'h0;
      for (int i = 0; i <= s.len(); i++) begin
         if (i < s.len()) w[8*(i%4) +: 8] = s[i];
         if (i % 4 == 3 || i == s.len()) begin
            put(w);
            w = 32'h0;
         end
      end
   endtask
   task automatic go();
      logic [31:0] q;
      xfer(1'b1, `CTNI_ADR_WPTR, {22'h0, wp}, q);
      do xfer(1'b0, `CTNI_ADR_RPTR, 32'h0, q); while (q[9:0] !== wp);
   endtask
endmodule

/* test/ctni_cmd_interp_bench.sv */
`include "ctni_cfg.svh"
module ctni_cmd_interp_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst_n, cyc, stb, we, ack, dl_valid, busy;
   logic [3:0] sel;
   logic [11:0] adr;
   logic [31:0] dat_w, dat_r, inf_end, img_a, img_w, img_h;
   ctni_pkg::ctni_dl_word_t dl_word;
   ctni_pkg::ctni_dl_word_t dl_q[$];
   int error_cnt = 0;
   int check_count = 0;
   ctni_cmd_interp ctni_cmd_interp_i (.REF_CLK(ref_clk), .RST_N(rst_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(sel),
      .WB_ADR_I(adr), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
      .INFLATE_END(inf_end), .IMG_ADDR(img_a), .IMG_W(img_w),
      .IMG_H(img_h), .DL_VALID(dl_valid), .DL_WORD(dl_word), .BUSY(busy));
   ctni_host_model ctni_host_model_i (.clk(ref_clk), .dat_i(dat_r),
      .ack(ack), .cyc(cyc), .stb(stb), .we(we), .sel(sel), .adr(adr),
      .dat(dat_w));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (dl_valid === 1'b1) dl_q.push_back(dl_word);
   task automatic report_and_stop();
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      ctni_host_model_i.xfer(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   task automatic cmd1(input logic [31:0] op, input logic [31:0] p);
      dl_q.delete();
      ctni_host_model_i.put(op);
      ctni_host_model_i.put(p);
   endtask
   task automatic num(input logic [15:0] o, input logic [31:0] v, string e);
      int n;
      n = 0;
      cmd1(`CTNI_OP_NUMBER, {16'd20, 16'd10});
      ctni_host_model_i.put({o, 16'd28});
      ctni_host_model_i.put(v);
      ctni_host_model_i.go();
      foreach (dl_q[i]) if (dl_q[i].tag === `CTNI_TAG_GLYPH) begin
         chk({8'h0, dl_q[i].body}, {24'h0, e[n]});
         n++;
      end
      chk(32'(n), 32'(e.len()));
   endtask
   task automatic sb(input logic [31:0] b, input logic [31:0] exp);
      cmd1(`CTNI_OP_SETBASE, b);
      ctni_host_model_i.go();
      rdc(`CTNI_ADR_BASE, exp);
   endtask
   task automatic txt(input logic [15:0] o, input logic [15:0] f, string s);
      cmd1(`CTNI_OP_TEXT, {16'd7, 16'd5});
      ctni_host_model_i.put({o, f});
      ctni_host_model_i.put_str(s);
      ctni_host_model_i.go();
      chk({24'h0, dl_q[0].tag}, {24'h0, `CTNI_TAG_HDR});
      chk({22'h0, dl_q[0].body[9:0]}, {22'h0, o[13], o[12], o[11], o[10],
          o[9], f[4:0]});
      chk({16'h0, dl_q[1].body[15:0]}, 32'd5);
      chk({16'h0, dl_q[2].body[15:0]}, 32'd7);
   endtask
   task automatic dlc(input int i, input logic [7:0] t, input logic [23:0] b);
      chk(dl_q[i], {t, b});
   endtask
   task automatic t_regs();
      logic [31:0] q;
      rdc(`CTNI_ADR_RPTR, 32'h0);
      rdc(`CTNI_ADR_BASE, 32'h0000000a);
      rdc(`CTNI_ADR_FILLW, 32'h0);
      rdc(12'h800, 32'h0);
      ctni_host_model_i.xfer(1'b1, `CTNI_ADR_RPTR, 32'h10, q);
      rdc(`CTNI_ADR_RPTR, 32'h0);
   endtask
   task automatic t_text();
      logic [15:0] opts[5] = '{16'h0, `CTNI_OPT_HCENTRE, `CTNI_OPT_VCENTRE,
         16'h0600, `CTNI_OPT_RIGHT};
      foreach (opts[i]) begin
         txt(opts[i], 16'd31, "A");
         chk(32'(dl_q.size()), 32'd4);
      end
      txt(16'h0, 16'd26, "A\n B");
      dlc(4, `CTNI_TAG_NEWLINE, 24'h000000);
      dlc(5, `CTNI_TAG_GLYPH, 24'h000020);
      dlc(6, `CTNI_TAG_GLYPH, 24'h000042);
      cmd1(`CTNI_OP_FILLW, 32'd160);
      ctni_host_model_i.go();
      rdc(`CTNI_ADR_FILLW, 32'd160);
      txt(`CTNI_OPT_WRAP, 16'd0, "A B");
      dlc(3, `CTNI_TAG_FILLW, 24'd160);
      dlc(5, `CTNI_TAG_SOFTBRK, 24'd160);
      dlc(6, `CTNI_TAG_GLYPH, 24'h000042);
      txt(`CTNI_STRING_A, 16'd1, "%d");
      chk({24'h0, dl_q[3].tag}, {24'h0, `CTNI_TAG_FMT});
      dlc(4, `CTNI_TAG_GLYPH, 24'h000064);
   endtask
   task automatic t_number();
      num(16'h0003, 32'd42, "042");
      num(16'h0103, 32'hffffffff, "-001");
      num(16'h0100, -32'sd42, "-42");
      num(16'h0000, 32'hffffffff, "4294967295");
      num(16'h0009, 32'd5, "000000005");
      num(16'h000a, 32'd7, "7");
      sb(32'd16, 32'd16);
      num(16'h0000, 32'd123456, "1E240");
      sb(32'd37, 32'd16);
      sb(32'd1, 32'd16);
      sb(32'd2, 32'd2);
      num(16'h0000, 32'd123456, "11110001001000000");
      sb(32'd36, 32'd36);
      num(16'h0000, 32'd123456, "2N9C");
      sb(32'd10, 32'd10);
   endtask
   task automatic t_matrix();
      logic [31:0] id[6] = '{`CTNI_ONE, 0, 0, 0, `CTNI_ONE, 0};
      logic [9:0] a;
      dl_q.delete();
      ctni_host_model_i.put(`CTNI_OP_SETMX);
      ctni_host_model_i.go();
      for (int i = 0; i < 6; i++) dlc(i, 8'(8'h15 + i), 24'h0);
      dl_q.delete();
      ctni_host_model_i.put(`CTNI_OP_LOADID);
      ctni_host_model_i.put(`CTNI_OP_SETMX);
      ctni_host_model_i.go();
      chk(32'(dl_q.size()), 32'd6);
      for (int i = 0; i < 6; i++) dlc(i, 8'(8'h15 + i), id[i][23:0]);
      a = ctni_host_model_i.wp;
      ctni_host_model_i.put(`CTNI_OP_GETMX);
      repeat (6) ctni_host_model_i.put(32'hdeadbeef);
      ctni_host_model_i.go();
      for (int i = 0; i < 6; i++) begin
         a = a + 10'h004;
         rdc({2'b00, a}, id[i]);
      end
   endtask
   task automatic t_query(input logic [31:0] v);
      logic [9:0] a;
      logic [31:0] q;
      inf_end <= v;
      img_a <= v ^ 32'h00000f00;
      img_w <= {16'h0, v[15:0]};
      img_h <= {16'h0, v[31:16]};
      cmd1(32'h0fffff99, 32'h0fffff99);
      a = ctni_host_model_i.wp;
      ctni_host_model_i.put(`CTNI_OP_GETPTR);
      ctni_host_model_i.put(32'h55555555);
      ctni_host_model_i.put(`CTNI_OP_GETPROPS);
      repeat (3) ctni_host_model_i.put(32'haaaaaaaa);
      ctni_host_model_i.xfer(1'b1, `CTNI_ADR_WPTR,
         {22'h0, ctni_host_model_i.wp}, q);
      @(negedge ref_clk);
      chk({31'h0, busy}, 32'h1);
      ctni_host_model_i.go();
      chk({31'h0, busy}, 32'h0);
      rdc({2'b00, a + 10'h004}, v);
      rdc({2'b00, a + 10'h00c}, v ^ 32'h00000f00);
      rdc({2'b00, a + 10'h010}, {16'h0, v[15:0]});
      rdc({2'b00, a + 10'h014}, {16'h0, v[31:16]});
   endtask
   initial begin
      rst_n = 1'b0;
      inf_end = 32'h0;
      img_a = 32'h0;
      img_w = 32'h0;
      img_h = 32'h0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_number();
      t_text();
      t_matrix();
      t_query(32'h00012344);
      t_query(32'h00ab0c08);
      report_and_stop();
   end
   initial begin
      #400000;
      error_cnt++;
      report_and_stop();
   end
endmodule
